// ==== mask_map.vh ====
// Constants for the alarm and warning enable mask block.
// Assumes inclusion by bare name from the design files.
`ifndef MASK_MAP_VH
`define MASK_MAP_VH

// =====================================================
// Register offsets inside the upper memory table
`define OFS_RSVD_A        8'hf9
`define OFS_SHUTDOWN_EN   8'hfa
`define OFS_RSVD_B        8'hfb
`define OFS_WARN_EN       8'hfc

// =====================================================
// Table numbers selected by the table-select bit
`define TABLE_PRIMARY     8'h01
`define TABLE_ALTERNATE   8'h05

// =====================================================
// Field positions and reset values
`define SD_BIT_BIAS_HI    3
`define SD_BIT_TX_POWER_HIGH     1
`define SD_BIT_TX_POWER_LOW     0
`define SD_USED_MASK      8'h0b
`define WARN_COMMON_MASK  8'hf0
`define WARN_PER_TX_MASK  8'h0f
`define RESET_SD_EN       8'h00
`define RESET_WARN_EN     8'h00

// =====================================================
// Shadow storage slot indices
`define SLOT_SD_TX1       2'h0
`define SLOT_SD_TX2       2'h1
`define SLOT_WARN_TX1     2'h2
`define SLOT_WARN_TX2     2'h3

`endif

// ==== nv_store.v ====
// Small nonvolatile shadow store of four bytes with a registered read port.
// Assumes the write strobe is one cycle and is produced in the mclk domain.
`timescale 1ns/1ps
`default_nettype none

module nv_store (
   input  wire       mclk,
   input  wire       clk_en,
   input  wire       wr_en,
   input  wire [1:0] wr_slot,
   input  wire [7:0] wr_data,
   input  wire [1:0] rd_slot,
   output reg  [7:0] rd_data
);

   reg [7:0] mem_q [0:3];

   // =====================================================
   // Storage cells, held across reset like EEPROM
   always @(posedge mclk) begin
      if (clk_en) begin
         if (wr_en) begin
            mem_q[wr_slot] <= wr_data;
         end
         rd_data <= mem_q[rd_slot];
      end
   end

endmodule
`default_nettype wire

// ==== alarm_warning_enable_masks.v ====
// Alarm and warning enable masks for a dual transmitter controller.
// Assumes a decoded byte-wide register port from the serial bus engine,
// password levels and grants already evaluated, flags from the monitors.
`timescale 1ns/1ps
`default_nettype none
`include "mask_map.vh"

module alarm_warning_enable_masks (
   input  wire       mclk,
   input  wire       reset,
   input  wire       clk_en,
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire       page_tx2,
   input  wire [7:0] table_sel,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   output reg        reg_ack,
   input  wire       mask_table_sel,
   input  wire       shadow_write_bypass,
   input  wire       upper_password_level,
   input  wire       lower_password_level,
   input  wire       table_region_rw_grant,
   input  wire       table_region_read_grant,
   input  wire [1:0] bias_high_alarm,
   input  wire [1:0] tx_power_high,
   input  wire [1:0] tx_power_low,
   input  wire [3:0] common_warning,
   input  wire [7:0] tx1_warning,
   input  wire [7:0] tx2_warning,
   output reg  [1:0] fault_gate_signal,
   output reg        tx_fault_interrupt,
   output reg        ee_busy
);

   // Synchronised flag inputs (monitor flags come from analog comparators)
   reg [1:0] bias_s1_q, bias_s2_q, txph_s1_q, txph_s2_q, txpl_s1_q, txpl_s2_q;
   reg [3:0] comw_s1_q, comw_s2_q;
   reg [7:0] w1_s1_q, w1_s2_q, w2_s1_q, w2_s2_q;

   // Working registers
   reg [7:0] sd_en_q [0:1];
   reg [3:0] warn_common_q;
   reg [3:0] warn_tx_q [0:1];

   // Power-up reload sequencer, one-hot
   localparam [3:0] ST_LOAD_ISSUE = 4'h1;
   localparam [3:0] ST_LOAD_WAIT  = 4'h2;
   localparam [3:0] ST_LOAD_TAKE  = 4'h4;
   localparam [3:0] ST_RUN        = 4'h8;
   reg  [3:0] state_q;
   reg  [1:0] slot_q;

   wire       rd_ok, wr_ok, tbl_hit, tx;
   wire       hit_sd, hit_warn, hit_rsvd;
   reg        ee_wr;
   reg  [1:0] ee_wslot;
   reg  [7:0] ee_wdata;
   wire [7:0] ee_rdata;
   reg        cw_pend_q;                                      // Shared bits owed to tx1 slot
   reg  [3:0] w1_lo_q;                                        // Stored tx1 warning nibble

   // =====================================================
   // Access decode
   assign tx      = page_tx2;
   assign tbl_hit = (table_sel == (mask_table_sel ? `TABLE_ALTERNATE
                                                  : `TABLE_PRIMARY));
   assign rd_ok   = upper_password_level | (lower_password_level &
                    (table_region_rw_grant | table_region_read_grant));
   assign wr_ok   = upper_password_level |
                    (lower_password_level & table_region_rw_grant);
   assign hit_sd   = tbl_hit & (reg_addr == `OFS_SHUTDOWN_EN);
   assign hit_warn = tbl_hit & (reg_addr == `OFS_WARN_EN);
   assign hit_rsvd = tbl_hit & ((reg_addr == `OFS_RSVD_A) | (reg_addr == `OFS_RSVD_B));

   // =====================================================
   // Shadow EEPROM commit data
   always @* begin
      ee_wr    = 1'b0;
      ee_wslot = `SLOT_SD_TX1;
      ee_wdata = reg_wdata;
      if (state_q == ST_RUN && reg_wr && wr_ok && !shadow_write_bypass) begin
         if (hit_sd) begin
            ee_wr    = 1'b1;
            ee_wslot = tx ? `SLOT_SD_TX2 : `SLOT_SD_TX1;
         end else if (hit_warn) begin
            ee_wr    = 1'b1;
            ee_wslot = tx ? `SLOT_WARN_TX2 : `SLOT_WARN_TX1;
         end
      end
      // Owed shared bits go out while the bus leaves the port free
      if (!ee_wr && cw_pend_q) begin
         ee_wr    = 1'b1;
         ee_wslot = `SLOT_WARN_TX1;
         ee_wdata = {warn_common_q, w1_lo_q};
      end
   end

   nv_store u_store (
      .mclk    (mclk),
      .clk_en  (clk_en),
      .wr_en   (ee_wr),
      .wr_slot (ee_wslot),
      .wr_data (ee_wdata),
      .rd_slot (slot_q),
      .rd_data (ee_rdata)
   );

   // =====================================================
   // Shared warning bits reload from the tx1 slot only, so a
   // page-two commit owes that slot a second write
   always @(posedge mclk) begin
      if (reset) begin
         cw_pend_q <= 1'b0;
      end else if (clk_en) begin
         if (ee_wr && ee_wslot == `SLOT_WARN_TX2) begin
            cw_pend_q <= 1'b1;
         end else if (ee_wr && ee_wslot == `SLOT_WARN_TX1) begin
            cw_pend_q <= 1'b0;
         end
      end
   end

   // Mirror of the stored tx1 nibble, so the owed write keeps it
   always @(posedge mclk) begin
      if (clk_en) begin
         if (state_q == ST_LOAD_TAKE && slot_q == `SLOT_WARN_TX1) begin
            w1_lo_q <= ee_rdata[3:0];
         end else if (ee_wr && ee_wslot == `SLOT_WARN_TX1) begin
            w1_lo_q <= ee_wdata[3:0];
         end
      end
   end

   // =====================================================
   // Input synchronisers
   always @(posedge mclk) begin
      if (clk_en) begin
         bias_s1_q <= bias_high_alarm;
         bias_s2_q <= bias_s1_q;
         txph_s1_q <= tx_power_high;
         txph_s2_q <= txph_s1_q;
         txpl_s1_q <= tx_power_low;
         txpl_s2_q <= txpl_s1_q;
         comw_s1_q <= common_warning;
         comw_s2_q <= comw_s1_q;
         w1_s1_q   <= tx1_warning;
         w1_s2_q   <= w1_s1_q;
         w2_s1_q   <= tx2_warning;
         w2_s2_q   <= w2_s1_q;
      end
   end

   // =====================================================
   // Reload sequencer and working registers
   always @(posedge mclk) begin
      if (reset) begin
         state_q       <= ST_LOAD_ISSUE;
         slot_q        <= `SLOT_SD_TX1;
         sd_en_q[0]    <= `RESET_SD_EN;
         sd_en_q[1]    <= `RESET_SD_EN;
         warn_common_q <= 4'h0;
         warn_tx_q[0]  <= 4'h0;
         warn_tx_q[1]  <= 4'h0;
         ee_busy       <= 1'b1;
      end else if (clk_en) begin
         case (state_q)
            ST_LOAD_ISSUE: begin
               state_q <= ST_LOAD_WAIT;
            end
            ST_LOAD_WAIT: begin
               state_q <= ST_LOAD_TAKE;
            end
            ST_LOAD_TAKE: begin
               // Copy stored byte into working register
               case (slot_q)
                  `SLOT_SD_TX1:  sd_en_q[0] <= ee_rdata;
                  `SLOT_SD_TX2:  sd_en_q[1] <= ee_rdata;
                  `SLOT_WARN_TX1: begin
                     warn_tx_q[0]  <= ee_rdata[3:0];
                     warn_common_q <= ee_rdata[7:4];
                  end
                  default: warn_tx_q[1] <= ee_rdata[3:0];
               endcase
               if (slot_q == `SLOT_WARN_TX2) begin
                  state_q <= ST_RUN;
                  ee_busy <= 1'b0;
               end else begin
                  state_q <= ST_LOAD_ISSUE;
               end
               slot_q <= slot_q + 2'h1;
            end
            ST_RUN: begin
               if (reg_wr && wr_ok) begin
                  if (hit_sd) begin
                     sd_en_q[tx] <= reg_wdata;
                  end else if (hit_warn) begin
                     warn_common_q <= reg_wdata[7:4];
                     warn_tx_q[tx] <= reg_wdata[3:0];
                  end
               end
            end
            default: begin
               state_q <= ST_LOAD_ISSUE;
            end
         endcase
      end
   end

   // =====================================================
   // Register read port, one cycle answer
   always @(posedge mclk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
         reg_ack   <= 1'b0;
      end else if (clk_en) begin
         reg_ack   <= (reg_rd | reg_wr) & (state_q == ST_RUN);
         reg_rdata <= 8'h00;
         if (reg_rd && rd_ok && state_q == ST_RUN) begin
            if (hit_sd) begin
               reg_rdata <= sd_en_q[tx];
            end else if (hit_warn) begin
               reg_rdata <= {warn_common_q, warn_tx_q[tx]};
            end else if (hit_rsvd) begin
               reg_rdata <= 8'h00;
            end
         end
      end
   end

   // =====================================================
   // Gated outputs
   always @(posedge mclk) begin
      if (reset) begin
         fault_gate_signal  <= 2'b00;
         tx_fault_interrupt <= 1'b0;
      end else if (clk_en) begin
         fault_gate_signal[0] <=
            (sd_en_q[0][`SD_BIT_BIAS_HI] & bias_s2_q[0]) |
            (sd_en_q[0][`SD_BIT_TX_POWER_HIGH]  & txph_s2_q[0]) |
            (sd_en_q[0][`SD_BIT_TX_POWER_LOW]  & txpl_s2_q[0]);
         fault_gate_signal[1] <=
            (sd_en_q[1][`SD_BIT_BIAS_HI] & bias_s2_q[1]) |
            (sd_en_q[1][`SD_BIT_TX_POWER_HIGH]  & txph_s2_q[1]) |
            (sd_en_q[1][`SD_BIT_TX_POWER_LOW]  & txpl_s2_q[1]);
         tx_fault_interrupt <= |(warn_common_q & comw_s2_q) |
                               |(warn_tx_q[0] & w1_s2_q[3:0]) |
                               |(warn_tx_q[1] & w2_s2_q[3:0]);
      end
   end

endmodule
`default_nettype wire

// ==== awem_asserts.sv ====
// Port checker for the alarm and warning enable mask block.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module awem_asserts (
   input wire logic       mclk,
   input wire logic       reset,
   input wire logic       clk_en,
   input wire logic       reg_rd,
   input wire logic [7:0] table_sel,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_ack,
   input wire logic       mask_table_sel,
   input wire logic       upper_password_level,
   input wire logic       lower_password_level,
   input wire logic       table_region_rw_grant,
   input wire logic       table_region_read_grant,
   input wire logic [1:0] bias_high_alarm,
   input wire logic [1:0] tx_power_high,
   input wire logic [1:0] tx_power_low,
   input wire logic [3:0] common_warning,
   input wire logic [7:0] tx1_warning,
   input wire logic [7:0] tx2_warning,
   input wire logic [1:0] fault_gate_signal,
   input wire logic       tx_fault_interrupt,
   input wire logic       ee_busy
);
   // ==========================================
   // Taken reads and their rights
   wire logic take = reg_rd && clk_en && !ee_busy;
   wire logic rd_ok = upper_password_level || (lower_password_level &&
      (table_region_rw_grant || table_region_read_grant));
   wire logic tbl_ok = table_sel == (mask_table_sel ? 8'h05 : 8'h01);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   a_read_acked:
      assert property (take |=> reg_ack) else $error("read without ack");
   a_busy_no_ack:
      assert property (ee_busy |=> !reg_ack) else $error("ack while reloading");
   a_refused_zero:
      assert property (take && !rd_ok |=> reg_rdata == 8'h00) else $error("refused read data");
   a_reserved_zero:
      assert property (take && (reg_addr == 8'hf9 || reg_addr == 8'hfb) |=> reg_rdata == 8'h00)
      else $error("reserved slot data");
   a_table_gate:
      assert property (take && !tbl_ok |=> reg_rdata == 8'h00) else $error("wrong table data");
   a_fault_cause:
      assert property ($rose(fault_gate_signal[0]) |->
         $past(bias_high_alarm[0] || tx_power_high[0] || tx_power_low[0], 3))
      else $error("gate without alarm");
   a_int_cause:
      assert property ($rose(tx_fault_interrupt) |->
         $past((|common_warning) || (|tx1_warning[3:0]) || (|tx2_warning[3:0]), 3))
      else $error("interrupt without warning");
   a_reload_len:
      assert property ($fell(reset) |-> ee_busy ##[10:14] !ee_busy) else $error("reload length");
endmodule
bind alarm_warning_enable_masks awem_asserts u_chk (.*);
`default_nettype wire

// ==== host_model.sv ====
// Host side of the register port, one transfer at a time.
// Assumes requests are one-cycle pulses answered by reg_ack.
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic       mclk,
   input  wire logic       reg_ack,
   input  wire logic [7:0] reg_rdata,
   output var  logic       reg_wr,
   output var  logic       reg_rd,
   output var  logic       page_tx2,
   output var  logic [7:0] table_sel,
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata
);
   // ==========================================
   // Idle port at time zero
   initial begin
      {reg_wr, reg_rd, page_tx2} = 3'h0;
      {table_sel, reg_addr, reg_wdata} = 24'h000000;
   end
   // Pulse a request, hold its qualifiers, wait bounded for ack
   task automatic xfer(input bit w, input bit pg, input logic [7:0] t, a, d,
                       output logic [7:0] q);
      @(posedge mclk);
      reg_wr <= w;
      reg_rd <= !w;
      page_tx2 <= pg;
      table_sel <= t;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      {reg_wr, reg_rd} <= 2'h0;
      q = 8'hxx;
      for (int n = 0; n < 4; n++) begin
         @(posedge mclk);
         if (reg_ack === 1'b1) begin
            q = reg_rdata;
            break;
         end
      end
   endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the alarm and warning enable mask block.
// Assumes host_model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic       mclk = 1'b0, reset = 1'b1, clk_en = 1'b1, mask_table_sel = 1'b0;
   logic       shadow_write_bypass = 1'b0, upper_password_level = 1'b1;
   logic       lower_password_level = 1'b0, table_region_rw_grant = 1'b0;
   logic       table_region_read_grant = 1'b0;
   logic [1:0] bias_high_alarm = 2'h0, tx_power_high = 2'h0, tx_power_low = 2'h0;
   logic [3:0] common_warning = 4'h0;
   logic [7:0] tx1_warning = 8'h00, tx2_warning = 8'h00, wc, ee_wc;
   logic [7:0] sd [2], wp [2], ee_sd [2], ee_wp [2];
   wire  logic reg_wr, reg_rd, page_tx2, reg_ack, tx_fault_interrupt, ee_busy;
   wire  logic [7:0] table_sel, reg_addr, reg_wdata, reg_rdata;
   wire  logic [1:0] fault_gate_signal;
   int         miscompares = 0, n_tests = 0, seed = 32'hc8916930;
   // ==========================================
   // Clock, design and host
   always #12.5 mclk = ~mclk;
   alarm_warning_enable_masks u_dut (.*);
   host_model u_host (.*);
   // Byte compare
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Verdict and end of run
   task automatic complete_run();
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Wait out the reload
   task automatic idle();
      for (int n = 0; n < 100 && ee_busy !== 1'b0; n++) @(posedge mclk);
   endtask
   // One access, then the model's view of it
   task automatic op(input bit w, input bit pg, input logic [7:0] t, a, d);
      logic [7:0] q, e;
      bit         ok;
      u_host.xfer(w, pg, t, a, d, q);
      ok = (t == (mask_table_sel ? 8'h05 : 8'h01)) && (upper_password_level ||
         (lower_password_level && (table_region_rw_grant || (!w && table_region_read_grant))));
      e = 8'h00;
      if (ok && a == 8'hfa) begin
         if (w) sd[pg] = d;
         if (w && !shadow_write_bypass) ee_sd[pg] = d;
         e = sd[pg] & 8'h0b;
      end
      if (ok && a == 8'hfc) begin
         if (w) {wc, wp[pg]} = {d, d};
         if (w && !shadow_write_bypass) {ee_wc, ee_wp[pg]} = {d, d};
         e = {wc[7:4], wp[pg][3:0]};
      end
      if (!w) cmp(q & (a == 8'hfa ? 8'h0b : 8'hff), e);
   endtask
   // Gated outputs against the model
   task automatic gates();
      logic [7:0] f;
      for (int i = 0; i < 2; i++) begin
         f = sd[i] & {4'h0, bias_high_alarm[i], 1'b0, tx_power_high[i], tx_power_low[i]};
         cmp({7'h0, fault_gate_signal[i]}, {7'h0, |f});
      end
      f = (wc & {common_warning, 4'h0}) | (wp[0] & tx1_warning & 8'h0f) | (wp[1] & tx2_warning & 8'h0f);
      cmp({7'h0, tx_fault_interrupt}, {7'h0, |f});
   endtask
   // Commit, random traffic, then reload after a second reset
   initial begin
      logic [31:0] r, s;
      logic [7:0]  q;
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      idle();
      op(1'b1, 1'b0, 8'h01, 8'hfa, 8'h0b);
      op(1'b1, 1'b1, 8'h01, 8'hfa, 8'h08);
      op(1'b1, 1'b0, 8'h01, 8'hfc, 8'ha5);
      op(1'b1, 1'b1, 8'h01, 8'hfc, 8'h5a);
      $display("commit test done");
      shadow_write_bypass <= 1'b1;
      for (int k = 0; k < 300; k++) begin
         r = $random(seed);
         s = $random(seed);
         @(posedge mclk);
         {bias_high_alarm, tx_power_high, tx_power_low, common_warning} <= r[9:0];
         {tx1_warning, tx2_warning} <= s[31:16];
         {mask_table_sel, upper_password_level, lower_password_level} <= r[12:10];
         {table_region_rw_grant, table_region_read_grant} <= r[14:13];
         op(r[15], r[16], r[17] ? 8'h03 : (r[18] ? 8'h05 : 8'h01), {5'h1f, r[21:19]}, s[7:0]);
         repeat (3) @(posedge mclk);
         gates();
      end
      $display("random test done");
      reset <= 1'b1;
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      {sd[0], sd[1], wc, wp[0], wp[1]} = {ee_sd[0], ee_sd[1], ee_wc, ee_wp[0], ee_wp[1]};
      idle();
      {upper_password_level, mask_table_sel} <= 2'h2;
      for (int k = 0; k < 4; k++) op(1'b0, k[0], 8'h01, k[1] ? 8'hfc : 8'hfa, 8'h00);
      gates();
      $display("reload test done");
      clk_en <= 1'b0;
      u_host.xfer(1'b1, 1'b0, 8'h01, 8'hfa, 8'h00, q);
      clk_en <= 1'b1;
      op(1'b0, 1'b0, 8'h01, 8'hfa, 8'h00);
      $display("freeze test done");
      complete_run();
   end
   // Watchdog on a hang
   initial begin
      #500000;
      miscompares++;
      complete_run();
   end
endmodule
`default_nettype wire
